/* src/flow_map.svh */
// Constants of the program flow and stack core
// Assumes inclusion by bare name from every design file that needs them
`ifndef FLOW_MAP_SVH
`define FLOW_MAP_SVH

// ****************************************
// Reset values
// ****************************************
`define PC_RESET       14'h0000
`define STACK_RESET    8'h00
`define DSP_RESET      8'h00

// ****************************************
// Vector table
// ****************************************
`define VEC_BUS_RESET  14'h0002
`define VEC_TMR_FAST   14'h0004
`define VEC_TMR_SLOW   14'h0006
`define VEC_EP0        14'h0008
`define VEC_EP1        14'h000A
`define VEC_EP2        14'h000C
`define VEC_EP3        14'h000E
`define VEC_EP4        14'h0010
`define VEC_RESERVED   14'h0012
`define VEC_CONV       14'h0014
`define VEC_GPIO       14'h0016
`define VEC_SERIAL     14'h0018
`define APP_BASE       14'h001A

// ****************************************
// Memory layout
// ****************************************
`define ROM_TEST_BASE  14'h1FE0
`define RAM_DEPTH      256
`define BYTE_ONE       8'h01
`define PAGE_ONE       6'h01
`define LEN_PAD        6'h00
`define FRAME_CARRY    7
`define FRAME_ZERO     6

`endif

/* src/flow_pkg.sv */
// Types shared by the program flow core, its assertions and its testbench
// Assumes the core and the instruction decoder share ref_clk
package flow_pkg;

	// ****************************************
	// Commands from the decoder
	// ****************************************
	typedef enum logic [3:0] {
		OP_NEXT                       = 4'h0,
		OP_PAGE                       = 4'h1,
		OP_JUMP                       = 4'h2,
		OP_CALL                       = 4'h3,
		OP_RET                        = 4'h4,
		OP_RETURN_FROM_INTERRUPT      = 4'h5,
		OP_LOAD_PROGRAM_STACK_POINTER = 4'h6,
		OP_PUSH                       = 4'h7,
		OP_POP                        = 4'h8,
		OP_OPND_RD                    = 4'h9,
		OP_OPND_WR                    = 4'hA,
		OP_DI                         = 4'hB,
		OP_EI                         = 4'hC
	} op_t;

	typedef enum logic [1:0] {
		AM_IMM = 2'h0,
		AM_DIR = 2'h1,
		AM_IDX = 2'h2
	} amode_t;

	typedef enum logic [3:0] {
		IRQ_NONE      = 4'h0,
		IRQ_BUS_RESET = 4'h1,
		IRQ_TMR_FAST  = 4'h2,
		IRQ_TMR_SLOW  = 4'h3,
		IRQ_EP0       = 4'h4,
		IRQ_EP1       = 4'h5,
		IRQ_EP2       = 4'h6,
		IRQ_EP3       = 4'h7,
		IRQ_EP4       = 4'h8,
		IRQ_RSVD      = 4'h9,
		IRQ_CONV      = 4'hA,
		IRQ_GPIO      = 4'hB,
		IRQ_SERIAL    = 4'hC
	} irq_src_t;

	typedef struct packed {
		op_t         op;
		amode_t      mode;
		logic [7:0]  operand;
		logic [13:0] target;
		logic [1:0]  len;
		logic [7:0]  acc;
		logic [7:0]  x;
	} cmd_t;

	// ****************************************
	// Core state
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE        = 5'h01,
		ST_SAVE_FIRST  = 5'h02,
		ST_SAVE_SECOND = 5'h04,
		ST_REST_SECOND = 5'h08,
		ST_REST_FIRST  = 5'h10
	} fsm_t;

	typedef struct packed {
		fsm_t        st;
		logic [13:0] pc;
		logic [7:0]  program_stack_pointer;
		logic [7:0]  dsp;
		logic        ie;
		logic        return_from_interrupt;
		logic [7:0]  save0;
		logic [7:0]  save1;
		logic [13:0] target;
		logic [7:0]  rd_data;
		logic        done;
		logic        carry;
		logic        zero;
		logic        flags_load;
		logic        irq_ack;
		logic        test_hit;
	} state_t;

endpackage : flow_pkg

/* src/data_ram.sv */
// Byte-wide data RAM built from flip-flops
// Assumes one access per cycle, read combinational, write on the clock
`timescale 1ns/1ps
`include "flow_map.svh"

module data_ram #(
	parameter int DEPTH = `RAM_DEPTH,
	parameter int AW    = 8,
	parameter int W     = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [W-1:0]  wdata,
	output logic      [W-1:0]  rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
	} ram_state_t;

	ram_state_t s_q;
	ram_state_t s_d;

	// ****************************************
	// Storage
	// ****************************************
	always_comb begin
		s_d = s_q;
		if (we) begin
			s_d.mem[addr] = wdata;
		end
	end

	// No reset: contents are undefined after power-up, as in real SRAM
	always_ff @(posedge ref_clk) begin
		s_q <= s_d;
	end

	assign rdata = s_q.mem[addr];

endmodule : data_ram

/* src/program_flow_core.sv */
// Program counter, program stack, data stack and operand addressing
// Assumes decoder and interrupt controller run on ref_clk; no pin inputs
`timescale 1ns/1ps
`include "flow_map.svh"

// Contract
// - 14-bit PC, reset clears to 0x0000
// - Low byte advances; high six by page-advance
// - Interrupt/call saves next PC, carry, zero
// - Program stack in RAM from 0x00 upward
// - Reset zeroes program stack pointer; grows up
// - Pointer loadable from accumulator, never readable
// - Interrupt: disable, write, inc, write, inc
// - Return-from-interrupt pops two, restores, then enables
// - Call pushes two, interrupt enable untouched
// - Plain return restores PC only, pops two
// - Push pre-decrements; pop post-increments
// - Data pointer resets 0; push wraps 0xFF
// - One 256-byte data RAM, shared
// - Immediate operand is the second byte
// - Direct operand uses instruction's RAM address
// - Indexed address is constant plus index
// - Bus reset, fast, slow timer vectors
// - Five endpoint vectors 0x0008-0x0010; 0x0012 reserved
// - Converter, I/O, serial vectors 0x0014-0x0018
// - Top 32 bytes of 8 KB reserved
// - Reset entry pushes nothing
module program_flow_core #(
	parameter bit BIG_ROM = 1'b1
) (
	input  wire logic               ref_clk,
	input  wire logic               nrst,
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire flow_pkg::cmd_t     cmd,
	input  wire logic               alu_carry,
	input  wire logic               alu_zero,
	input  wire logic               irq_req,
	input  wire flow_pkg::irq_src_t irq_src,
	output logic                    irq_ack,
	output logic                    irq_enabled,
	output logic [13:0]             fetch_addr,
	output logic                    fetch_in_test_area,
	output logic                    done,
	output logic [7:0]              rd_data,
	output logic                    flags_load,
	output logic                    carry_out,
	output logic                    zero_out
);

	flow_pkg::state_t s_q;
	flow_pkg::state_t s_d;

	logic        ram_we;
	logic [7:0]  ram_addr;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_rdata;
	logic [13:0] vec_addr;
	logic        vec_ok;
	logic        irq_take;
	logic [7:0]  opnd_addr;
	logic [7:0]  stack_ptr_dec;
	logic [7:0]  stack_ptr_inc;
	logic [7:0]  dsp_dec;
	logic [7:0]  dsp_inc;
	logic [7:0]  frame_hi;
	logic [7:0]  frame_lo;
	logic [13:0] restore_pc;
	logic        restore_carry;
	logic        restore_zero;

	// ****************************************
	// Vector table
	// ****************************************
	always_comb begin
		vec_ok   = 1'b1;
		vec_addr = `PC_RESET;
		case (irq_src)
			flow_pkg::IRQ_BUS_RESET: vec_addr = `VEC_BUS_RESET;
			flow_pkg::IRQ_TMR_FAST:  vec_addr = `VEC_TMR_FAST;
			flow_pkg::IRQ_TMR_SLOW:  vec_addr = `VEC_TMR_SLOW;
			flow_pkg::IRQ_EP0:       vec_addr = `VEC_EP0;
			flow_pkg::IRQ_EP1:       vec_addr = `VEC_EP1;
			flow_pkg::IRQ_EP2:       vec_addr = `VEC_EP2;
			flow_pkg::IRQ_EP3:       vec_addr = `VEC_EP3;
			flow_pkg::IRQ_EP4:       vec_addr = `VEC_EP4;
			flow_pkg::IRQ_CONV:      vec_addr = `VEC_CONV;
			flow_pkg::IRQ_GPIO:      vec_addr = `VEC_GPIO;
			flow_pkg::IRQ_SERIAL:    vec_addr = `VEC_SERIAL;
			// Reserved slot and vector zero never taken as interrupts
			default: begin
				vec_ok   = 1'b0;
				vec_addr = `VEC_RESERVED;
			end
		endcase
	end

	// ****************************************
	// Address helpers
	// ****************************************
	assign stack_ptr_dec = s_q.program_stack_pointer - `BYTE_ONE;
	assign stack_ptr_inc = s_q.program_stack_pointer + `BYTE_ONE;
	assign dsp_dec       = s_q.dsp - `BYTE_ONE;
	assign dsp_inc       = s_q.dsp + `BYTE_ONE;

	// ****************************************
	// Operand addressing
	// ****************************************
	// Eight-bit sum wraps inside the RAM
	assign opnd_addr = (cmd.mode == flow_pkg::AM_IDX) ? cmd.operand + cmd.x
	                                                  : cmd.operand;

	// ****************************************
	// Program stack frame
	// ****************************************
	// Flags ride above the page bits so one read restores both
	assign frame_hi      = {alu_carry, alu_zero, s_q.pc[13:8]};
	// Return address wraps inside its page, as a sequential fetch does
	assign frame_lo      = s_q.pc[7:0] + {`LEN_PAD, cmd.len};
	assign restore_pc    = {ram_rdata[5:0], s_q.save1};
	assign restore_carry = ram_rdata[`FRAME_CARRY];
	assign restore_zero  = ram_rdata[`FRAME_ZERO];

	// ****************************************
	// Command handshake
	// ****************************************
	assign irq_take  = (s_q.st == flow_pkg::ST_IDLE) && irq_req && s_q.ie && vec_ok;
	// Interrupt wins over a pending command at an instruction boundary
	assign cmd_ready = (s_q.st == flow_pkg::ST_IDLE) && !irq_take;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d            = s_q;
		s_d.done       = 1'b0;
		s_d.flags_load = 1'b0;
		s_d.irq_ack    = 1'b0;
		ram_we         = 1'b0;
		ram_addr       = s_q.program_stack_pointer;
		ram_wdata      = s_q.save0;
		case (s_q.st)
			flow_pkg::ST_IDLE: begin
				if (irq_take) begin
					s_d.ie      = 1'b0;
					s_d.save0   = frame_hi;
					s_d.save1   = s_q.pc[7:0];
					s_d.target  = vec_addr;
					s_d.irq_ack = 1'b1;
					s_d.st      = flow_pkg::ST_SAVE_FIRST;
				end else if (cmd_valid) begin
					s_d.done = 1'b1;
					case (cmd.op)
						flow_pkg::OP_NEXT: begin
							s_d.pc[7:0] = s_q.pc[7:0] + {`LEN_PAD, cmd.len};
						end
						flow_pkg::OP_PAGE: begin
							s_d.pc[13:8] = s_q.pc[13:8] + `PAGE_ONE;
							s_d.pc[7:0]  = s_q.pc[7:0] + `BYTE_ONE;
						end
						flow_pkg::OP_JUMP: begin
							s_d.pc = cmd.target;
						end
						flow_pkg::OP_CALL: begin
							s_d.done   = 1'b0;
							s_d.save0  = frame_hi;
							s_d.save1  = frame_lo;
							s_d.target = cmd.target;
							s_d.st     = flow_pkg::ST_SAVE_FIRST;
						end
						flow_pkg::OP_RET, flow_pkg::OP_RETURN_FROM_INTERRUPT: begin
							s_d.done = 1'b0;
							s_d.st   = flow_pkg::ST_REST_SECOND;
							s_d.return_from_interrupt =
								(cmd.op == flow_pkg::OP_RETURN_FROM_INTERRUPT);
						end
						flow_pkg::OP_LOAD_PROGRAM_STACK_POINTER: begin
							s_d.program_stack_pointer = cmd.acc;
						end
						flow_pkg::OP_PUSH: begin
							s_d.dsp   = dsp_dec;
							ram_we    = 1'b1;
							ram_addr  = dsp_dec;
							ram_wdata = cmd.acc;
						end
						flow_pkg::OP_POP: begin
							ram_addr    = s_q.dsp;
							s_d.rd_data = ram_rdata;
							s_d.dsp     = dsp_inc;
						end
						flow_pkg::OP_OPND_RD: begin
							ram_addr = opnd_addr;
							if (cmd.mode == flow_pkg::AM_IMM) begin
								s_d.rd_data = cmd.operand;
							end else begin
								s_d.rd_data = ram_rdata;
							end
						end
						flow_pkg::OP_OPND_WR: begin
							// An immediate has no location to write
							ram_addr  = opnd_addr;
							ram_wdata = cmd.acc;
							ram_we    = (cmd.mode != flow_pkg::AM_IMM);
						end
						flow_pkg::OP_DI: begin
							s_d.ie = 1'b0;
						end
						flow_pkg::OP_EI: begin
							s_d.ie = 1'b1;
						end
						default: begin
							s_d.done = 1'b1;
						end
					endcase
				end
			end
			flow_pkg::ST_SAVE_FIRST: begin
				ram_we                    = 1'b1;
				ram_addr                  = s_q.program_stack_pointer;
				ram_wdata                 = s_q.save0;
				s_d.program_stack_pointer = stack_ptr_inc;
				s_d.st                    = flow_pkg::ST_SAVE_SECOND;
			end
			flow_pkg::ST_SAVE_SECOND: begin
				ram_we                    = 1'b1;
				ram_addr                  = s_q.program_stack_pointer;
				ram_wdata                 = s_q.save1;
				s_d.program_stack_pointer = stack_ptr_inc;
				s_d.pc                    = s_q.target;
				s_d.done                  = 1'b1;
				s_d.st                    = flow_pkg::ST_IDLE;
			end
			flow_pkg::ST_REST_SECOND: begin
				ram_addr                  = stack_ptr_dec;
				s_d.program_stack_pointer = stack_ptr_dec;
				s_d.save1                 = ram_rdata;
				s_d.st                    = flow_pkg::ST_REST_FIRST;
			end
			flow_pkg::ST_REST_FIRST: begin
				ram_addr                  = stack_ptr_dec;
				s_d.program_stack_pointer = stack_ptr_dec;
				s_d.pc                    = restore_pc;
				if (s_q.return_from_interrupt) begin
					s_d.carry      = restore_carry;
					s_d.zero       = restore_zero;
					s_d.flags_load = 1'b1;
					s_d.ie         = 1'b1;
				end
				s_d.done = 1'b1;
				s_d.st   = flow_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = flow_pkg::ST_IDLE;
			end
		endcase
		// Flagged only; the fetch still proceeds
		s_d.test_hit = BIG_ROM && (s_d.pc >= `ROM_TEST_BASE);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_q                       <= '0;
			s_q.st                    <= flow_pkg::ST_IDLE;
			s_q.pc                    <= `PC_RESET;
			s_q.program_stack_pointer <= `STACK_RESET;
			s_q.dsp                   <= `DSP_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Shared data RAM
	// ****************************************
	data_ram #(
		.DEPTH (`RAM_DEPTH),
		.AW    (8),
		.W     (8)
	) u_ram (
		.ref_clk (ref_clk),
		.we      (ram_we),
		.addr    (ram_addr),
		.wdata   (ram_wdata),
		.rdata   (ram_rdata)
	);

	// ****************************************
	// Outputs
	// ****************************************
	// Program counter leaves only as fetch address
	assign fetch_addr         = s_q.pc;
	assign fetch_in_test_area = s_q.test_hit;
	assign irq_ack            = s_q.irq_ack;
	assign irq_enabled        = s_q.ie;
	assign done               = s_q.done;
	assign rd_data            = s_q.rd_data;
	assign flags_load         = s_q.flags_load;
	assign carry_out          = s_q.carry;
	assign zero_out           = s_q.zero;

endmodule : program_flow_core

/* tb/flow_assertions.sv */
// Concurrent checks on the ports of the program flow core
// Assumes a bind from the bench top; one ref_clk domain
`timescale 1ns/1ps
`include "flow_map.svh"
module flow_assertions #(
	parameter bit BIG_ROM = 1'b1
) (
	input logic               ref_clk,
	input logic               nrst,
	input logic               cmd_valid,
	input logic               cmd_ready,
	input flow_pkg::cmd_t     cmd,
	input logic               alu_carry,
	input logic               alu_zero,
	input logic               irq_req,
	input flow_pkg::irq_src_t irq_src,
	input logic               irq_ack,
	input logic               irq_enabled,
	input logic [13:0]        fetch_addr,
	input logic               fetch_in_test_area,
	input logic               done,
	input logic [7:0]         rd_data,
	input logic               flags_load,
	input logic               carry_out,
	input logic               zero_out
);
	logic take;
	assign take = cmd_valid && cmd_ready;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// ********
	// Checks
	// ********
	reset_clear_a: assert property (disable iff (1'b0) !nrst |=> fetch_addr == 14'h0000)
		else $error("pc not cleared by reset");
	next_low_a: assert property (take && cmd.op == flow_pkg::OP_NEXT |=>
		fetch_addr == {$past(fetch_addr[13:8]), 8'($past(fetch_addr[7:0]) + $past(cmd.len))})
		else $error("next moved pc wrongly");
	ack_state_a: assert property (irq_ack |-> !irq_enabled && !cmd_ready)
		else $error("interrupts still enabled at acknowledge");
	ack_done_a: assert property (irq_ack |-> !done ##2 done)
		else $error("interrupt entry not two writes long");
	vector_pc_a: assert property (irq_ack |-> ##2
		fetch_addr == {9'h000, $past(irq_src, 3), 1'b0})
		else $error("wrong interrupt vector");
	test_area_a: assert property (fetch_in_test_area == (BIG_ROM && fetch_addr >= `ROM_TEST_BASE))
		else $error("test area flag wrong");
	return_from_interrupt_end_a: assert property (take && cmd.op == flow_pkg::OP_RETURN_FROM_INTERRUPT |->
		##3 done && flags_load && irq_enabled)
		else $error("interrupt return did not restore");
	call_ie_a: assert property (take && cmd.op == flow_pkg::OP_CALL |->
		##3 done && irq_enabled == $past(irq_enabled, 3))
		else $error("call changed interrupt enable");
	ret_flags_a: assert property (take && cmd.op == flow_pkg::OP_RET |-> ##3 done && !flags_load)
		else $error("plain return touched flags");
	imm_value_a: assert property (take && cmd.op == flow_pkg::OP_OPND_RD &&
		cmd.mode == flow_pkg::AM_IMM |=> done && rd_data == $past(cmd.operand))
		else $error("immediate operand wrong");
	cover property (irq_ack);
	cover property (flags_load);
	cover property (fetch_in_test_area);
endmodule : flow_assertions

/* tb/instr_mem_model.sv */
// Instruction memory model giving the second byte of an instruction
// Assumes fetch_addr comes registered from the core
`timescale 1ns/1ps
module instr_mem_model (
	input  logic [13:0] fetch_addr,
	output logic [7:0]  second_byte
);
	logic [13:0] next_addr;
	// Combinational: the fetch address is already registered
	assign next_addr = fetch_addr + 14'h0001;
	assign second_byte = next_addr[7:0] ^ {next_addr[13:8], 2'h0};
endmodule : instr_mem_model

/* tb/testbench.sv */
// Self-checking bench for the program flow core
// Assumes flow_pkg, the core and the partner model compiled before
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [13:0] pc;
		logic [7:0]  rd;
		logic        use_rd;
	} note_t;
	logic               ref_clk = 1'b0;
	logic               nrst = 1'b0;
	logic               cmd_valid = 1'b0;
	flow_pkg::cmd_t     cmd = '0;
	logic               alu_carry = 1'b0;
	logic               alu_zero = 1'b0;
	logic               irq_req = 1'b0;
	flow_pkg::irq_src_t irq_src = flow_pkg::IRQ_NONE;
	flow_pkg::amode_t   md = flow_pkg::AM_IMM;
	logic               cmd_ready, irq_ack, irq_enabled, done, flags_load;
	logic               carry_out, zero_out, in_test, cy, zr, seen;
	logic [13:0]        fetch_addr, pc, ret_pc, tg;
	logic [7:0]         rd_data, second_byte, a, b, xv, base;
	logic [1:0]         ln = 2'h0;
	note_t              notes[$];
	note_t              n;
	int                 errors = 0;
	int                 num_checks = 0;

	always #12.5 ref_clk = ~ref_clk;

	program_flow_core #(.BIG_ROM(1'b1)) DUT (.ref_clk(ref_clk), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .alu_carry(alu_carry),
		.alu_zero(alu_zero), .irq_req(irq_req), .irq_src(irq_src), .irq_ack(irq_ack),
		.irq_enabled(irq_enabled), .fetch_addr(fetch_addr), .fetch_in_test_area(in_test),
		.done(done), .rd_data(rd_data), .flags_load(flags_load), .carry_out(carry_out),
		.zero_out(zero_out));
	instr_mem_model imem (.fetch_addr(fetch_addr), .second_byte(second_byte));

	// ********
	// Tasks
	// ********
	task automatic cmp(input string what, input logic [13:0] exp, input logic [13:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic results();
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	task automatic wait_done();
		for (int i = 0; i < 8 && done !== 1'b1; i++) begin
			@(negedge ref_clk);
		end
		if (done !== 1'b1) begin
			errors++;
			results();
		end
		// Extra cycle so no signal is driven twice in one step
		@(negedge ref_clk);
	endtask : wait_done

	task automatic op(input flow_pkg::op_t o, input logic [7:0] v, input logic [7:0] av,
		input logic [7:0] erd, input logic use_rd);
		notes.push_back('{pc, erd, use_rd});
		cmd = '{o, md, v, tg, ln, av, xv};
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		wait_done();
	endtask : op

	always @(negedge ref_clk) begin
		if (done === 1'b1 && notes.size() == 0) cmp("note_queue", 14'h0001, 14'h0000);
		else if (done === 1'b1) begin
			n = notes.pop_front();
			cmp("fetch_addr", n.pc, fetch_addr);
			if (n.use_rd) cmp("rd_data", {6'h00, n.rd}, {6'h00, rd_data});
		end
	end

	// ********
	// Scenarios
	// ********
	initial begin
		void'($urandom(91286));
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		cmp("fetch_addr", 14'h0000, fetch_addr);
		cmp("irq_enabled", 14'h0000, {13'h0000, irq_enabled});
		pc = 14'h03FE;
		tg = pc;
		op(flow_pkg::OP_JUMP, 8'h00, 8'h00, 8'h00, 1'b0);
		pc = 14'h0300;
		ln = 2'h2;
		op(flow_pkg::OP_NEXT, 8'h00, 8'h00, 8'h00, 1'b0);
		pc = 14'h0401;
		op(flow_pkg::OP_PAGE, 8'h00, 8'h00, 8'h00, 1'b0);
		{a, b, xv} = 24'($urandom);
		op(flow_pkg::OP_PUSH, 8'h00, a, 8'h00, 1'b0);
		op(flow_pkg::OP_PUSH, 8'h00, b, 8'h00, 1'b0);
		md = flow_pkg::AM_DIR;
		op(flow_pkg::OP_OPND_RD, 8'hFF, 8'h00, a, 1'b1);
		op(flow_pkg::OP_POP, 8'h00, 8'h00, b, 1'b1);
		op(flow_pkg::OP_POP, 8'h00, 8'h00, a, 1'b1);
		op(flow_pkg::OP_OPND_WR, 8'h80, b, 8'h00, 1'b0);
		op(flow_pkg::OP_OPND_RD, 8'h80, 8'h00, b, 1'b1);
		md = flow_pkg::AM_IDX;
		op(flow_pkg::OP_OPND_RD, 8'hFF - xv, 8'h00, a, 1'b1);
		md = flow_pkg::AM_IMM;
		op(flow_pkg::OP_OPND_RD, second_byte, 8'h00, second_byte, 1'b1);
		tg = 14'h1FE4;
		for (int k = 0; k < 2; k++) begin
			{cy, zr} = 2'($urandom);
			{alu_carry, alu_zero} = {cy, zr};
			ret_pc = {pc[13:8], pc[7:0] + 8'h02};
			base = {1'b0, k[0], 6'h00};
			pc = tg;
			op(flow_pkg::OP_CALL, 8'h00, 8'h00, 8'h00, 1'b0);
			cmp("in_test", 14'h0001, {13'h0000, in_test});
			md = flow_pkg::AM_DIR;
			op(flow_pkg::OP_OPND_RD, base, 8'h00, {cy, zr, ret_pc[13:8]}, 1'b1);
			op(flow_pkg::OP_OPND_RD, base + 8'h01, 8'h00, ret_pc[7:0], 1'b1);
			md = flow_pkg::AM_IMM;
			pc = ret_pc;
			op(flow_pkg::OP_RET, 8'h00, 8'h00, 8'h00, 1'b0);
			cmp("flags", 14'h0000, {12'h000, carry_out, zero_out});
			cmp("in_test", 14'h0000, {13'h0000, in_test});
			op(flow_pkg::OP_LOAD_PROGRAM_STACK_POINTER, 8'h00, 8'h40, 8'h00, 1'b0);
		end
		op(flow_pkg::OP_EI, 8'h00, 8'h00, 8'h00, 1'b0);
		for (int s = 1; s < 13; s++) begin
			{cy, zr} = 2'($urandom);
			{alu_carry, alu_zero} = {cy, zr};
			irq_src = flow_pkg::irq_src_t'(s);
			irq_req = 1'b1;
			if (s == 9) begin
				seen = 1'b0;
				repeat (4) begin
					@(negedge ref_clk);
					seen = seen | irq_ack;
				end
				cmp("irq_ack", 14'h0000, {13'h0000, seen});
				irq_req = 1'b0;
				@(negedge ref_clk);
			end else begin
				notes.push_back('{{9'h000, 4'(s), 1'b0}, 8'h00, 1'b0});
				wait_done();
				irq_req = 1'b0;
				cmp("irq_enabled", 14'h0000, {13'h0000, irq_enabled});
				{alu_carry, alu_zero} = ~{cy, zr};
				op(flow_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 8'h00, 1'b0);
				cmp("flags", {12'h000, cy, zr}, {12'h000, carry_out, zero_out});
				cmp("irq_enabled", 14'h0001, {13'h0000, irq_enabled});
			end
		end
		results();
	end
endmodule : testbench

bind program_flow_core flow_assertions #(.BIG_ROM(BIG_ROM)) chk (.ref_clk(ref_clk),
	.nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
	.alu_carry(alu_carry), .alu_zero(alu_zero), .irq_req(irq_req), .irq_src(irq_src),
	.irq_ack(irq_ack), .irq_enabled(irq_enabled), .fetch_addr(fetch_addr),
	.fetch_in_test_area(fetch_in_test_area), .done(done), .rd_data(rd_data),
	.flags_load(flags_load), .carry_out(carry_out), .zero_out(zero_out));
